/* hdl/flow_stats_pkg.sv */
package flow_stats_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets, each register spans one 16-byte group
    localparam logic [11:0] ctrl_one_offset = 12'h000;
    localparam logic [11:0] pause_timer_offset = 12'h010;
    localparam logic [11:0] watermark_offset = 12'h020;
    localparam logic [11:0] status_offset = 12'h030;
    localparam logic [11:0] collision_offset = 12'h040;
    localparam logic [11:0] phy_support_offset = 12'h050;

    // alias kind, taken from address bits 3:2 (0x0, 0x4, 0x8, 0xc)
    localparam logic [1:0] alias_write = 2'h0;
    localparam logic [1:0] alias_clear = 2'h1;
    localparam logic [1:0] alias_set = 2'h2;
    localparam logic [1:0] alias_invert = 2'h3;

    // legal byte enable patterns: one word or one aligned halfword
    localparam logic [3:0] be_word = 4'hf;
    localparam logic [3:0] be_low_half = 4'h3;
    localparam logic [3:0] be_high_half = 4'hc;

    ////////////////////////////////////////////////////////////////////////////
    // controller_control_one fields
    localparam int ctrl_on_bit = 15;
    localparam int ctrl_rx_enable_bit = 8;
    localparam int ctrl_auto_pause_bit = 7;
    localparam int ctrl_manual_pause_bit = 4;
    localparam int ctrl_decrement_bit = 0;
    localparam logic [31:0] ctrl_one_mask = 32'h0000_8190;
    localparam logic [31:0] ctrl_one_reset = 32'h0000_0000;

    // watermark register fields
    localparam int wm_full_lsb = 0;
    localparam int wm_empty_lsb = 8;
    localparam logic [15:0] watermark_reset = 16'h0000;

    // status register fields
    localparam int status_count_lsb = 16;
    localparam int status_pause_bit = 0;

    // phy_support_control fields
    localparam int phy_reset_bit = 11;
    localparam int phy_speed_bit = 8;
    localparam logic [31:0] phy_support_mask = 32'h0000_0900;
    localparam logic [31:0] phy_support_reset = 32'h0000_0000;

    // counters and pause values
    localparam logic [15:0] pause_timer_reset = 16'h0000;
    localparam logic [15:0] pause_zero_value = 16'h0000;
    localparam logic [15:0] collision_reset = 16'h0000;
    localparam logic [7:0] rx_count_max = 8'hff;
    localparam int resend_quanta = 128;
    localparam int resend_divisor = 2;
    localparam int resend_scale = resend_quanta / resend_divisor;

    typedef enum {pause_idle, pause_running} pause_state_t;

endpackage

/* hdl/ethernet_flow_control_stats.sv */
`timescale 1ns/100ps
// Behaviour
// - with auto pause on, flow control turns on when buffer count reaches full mark
// - with auto pause on, flow control turns off when count falls to empty mark
// - enabling manual pause sends a pause frame with the programmed timer value
// - while manual pause stays on, resend every 128*value/2 tx clock cycles
// - resend interval is counted on the tx clock, 2.5 or 25 MHz by speed
// - clearing manual pause sends one pause frame with a zero timer value
// - decrement bit reads zero; writing one lowers buffer count, zero does nothing
// - increment and decrement in the same cycle leave the buffer count unchanged
// - 16-bit counter counts frames sent on second try after one collision
// - reading the collision counter clears it unless byte lanes 0 and 1 are off
// - phy interface reset bit holds the tx link logic in reset while set
// - phy interface speed bit selects 100 Mbps when set, 10 Mbps when clear
// - 16-bit and 32-bit accesses are taken, 8-bit accesses are ignored
// - unimplemented bits 31 to 12 of the phy support register read zero
// - each register except status has clear, set and invert aliases at +0x4, +0x8, +0xc
module ethernet_flow_control_stats
(
    // system clock and reset
    input wire logic clock,
    input wire logic resetn,
    // link transmit clock
    input wire logic tx_clock,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0] reg_byte_en,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // receive buffer bookkeeping
    input wire logic rx_buffer_increment,
    output logic [7:0] rx_buffer_count,
    output logic flow_control_on,
    output logic controller_on,
    output logic receive_path_enable,
    // reduced phy interface controls
    output logic reduced_phy_if_reset,
    output logic reduced_phy_if_speed,
    // transmit side, tx_clock domain
    input wire logic second_try_tx_done,
    output logic pause_frame_send,
    output logic [15:0] pause_frame_value
);

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [31:0] ctrl_r, phy_r, rdata_r;
    logic [15:0] ptv_r, wm_r, col_cnt_r;
    logic [7:0] rx_cnt_r;
    logic auto_active_r, ptv_tgl_r;

    // collision event crossing from tx domain
    logic col_tgl_r, col_s1_r, col_s2_r, col_s3_r;

    // tx domain state
    logic man_s1_r, man_s2_r, hold_s1_r, hold_s2_r, ptv_s1_r, ptv_s2_r, ptv_s3_r;
    logic [15:0] tx_ptv_r, pause_value_r;
    logic [21:0] resend_cnt_r;
    flow_stats_pkg::pause_state_t pause_state_r;
    logic pause_send_r;

    ////////////////////////////////////////////////////////////////////////////
    // address decode and byte lanes
    logic aligned, be_legal, wr_ok, rd_ok;
    logic [11:0] reg_base;
    logic [1:0] alias_kind;
    logic [31:0] lane_mask;
    logic hit_ctrl, hit_ptv, hit_wm, hit_status, hit_col, hit_phy;

    assign aligned = (reg_addr[1:0] == 2'h0);
    assign be_legal = (reg_byte_en == flow_stats_pkg::be_word)
        || (reg_byte_en == flow_stats_pkg::be_low_half)
        || (reg_byte_en == flow_stats_pkg::be_high_half);
    assign reg_base = {reg_addr[11:4], 4'h0};
    assign alias_kind = reg_addr[3:2];
    assign wr_ok = reg_write && aligned && be_legal;
    assign rd_ok = reg_read && aligned && be_legal;

    generate
        for (genvar lane = 0; lane < 4; lane++)
        begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{reg_byte_en[lane]}};
        end
    endgenerate

    assign hit_ctrl = (reg_base == flow_stats_pkg::ctrl_one_offset);
    assign hit_ptv = (reg_base == flow_stats_pkg::pause_timer_offset);
    assign hit_wm = (reg_base == flow_stats_pkg::watermark_offset);
    assign hit_status = (reg_base == flow_stats_pkg::status_offset);
    assign hit_col = (reg_base == flow_stats_pkg::collision_offset);
    assign hit_phy = (reg_base == flow_stats_pkg::phy_support_offset);

    // plain write or clear/set/invert alias on the enabled lanes
    function automatic logic [31:0] alias_apply(input logic [31:0] old_value,
        input logic [31:0] wr_value, input logic [31:0] lanes, input logic [1:0] kind);
        logic [31:0] sel;
        sel = wr_value & lanes;
        case (kind)
            flow_stats_pkg::alias_clear: alias_apply = old_value & ~sel;
            flow_stats_pkg::alias_set: alias_apply = old_value | sel;
            flow_stats_pkg::alias_invert: alias_apply = old_value ^ sel;
            default: alias_apply = (old_value & ~lanes) | sel;
        endcase
    endfunction

    logic [31:0] ctrl_nxt, ptv_nxt, wm_nxt, phy_nxt, col_alias_nxt;
    logic dec_req;

    assign ctrl_nxt = alias_apply(ctrl_r, reg_wdata, lane_mask, alias_kind)
        & flow_stats_pkg::ctrl_one_mask;
    assign ptv_nxt = alias_apply({16'h0000, ptv_r}, reg_wdata, lane_mask, alias_kind);
    assign wm_nxt = alias_apply({16'h0000, wm_r}, reg_wdata, lane_mask, alias_kind);
    assign phy_nxt = alias_apply(phy_r, reg_wdata, lane_mask, alias_kind)
        & flow_stats_pkg::phy_support_mask;
    assign col_alias_nxt = alias_apply({16'h0000, col_cnt_r}, reg_wdata, lane_mask,
        alias_kind);

    // decrement is a write-one strobe; a clear alias never produces a one
    assign dec_req = wr_ok && hit_ctrl && (alias_kind != flow_stats_pkg::alias_clear)
        && reg_wdata[flow_stats_pkg::ctrl_decrement_bit]
        && reg_byte_en[0];

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            ctrl_r <= flow_stats_pkg::ctrl_one_reset;
        else if (wr_ok && hit_ctrl)
            ctrl_r <= ctrl_nxt;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ptv_r <= flow_stats_pkg::pause_timer_reset;
            ptv_tgl_r <= 1'b0;
        end
        else if (wr_ok && hit_ptv)
        begin
            ptv_r <= ptv_nxt[15:0];
            ptv_tgl_r <= ~ptv_tgl_r;
        end
    end

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            wm_r <= flow_stats_pkg::watermark_reset;
        else if (wr_ok && hit_wm)
            wm_r <= wm_nxt[15:0];

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            phy_r <= flow_stats_pkg::phy_support_reset;
        else if (wr_ok && hit_phy)
            phy_r <= phy_nxt;

    assign controller_on = ctrl_r[flow_stats_pkg::ctrl_on_bit];
    assign receive_path_enable = ctrl_r[flow_stats_pkg::ctrl_rx_enable_bit];
    assign reduced_phy_if_reset = phy_r[flow_stats_pkg::phy_reset_bit];
    assign reduced_phy_if_speed = phy_r[flow_stats_pkg::phy_speed_bit];

    ////////////////////////////////////////////////////////////////////////////
    // receive buffer count, saturating at both ends
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            rx_cnt_r <= 8'h00;
        else if (rx_buffer_increment && !dec_req && rx_cnt_r != flow_stats_pkg::rx_count_max)
            rx_cnt_r <= rx_cnt_r + 8'h01;
        else if (dec_req && !rx_buffer_increment && rx_cnt_r != 8'h00)
            rx_cnt_r <= rx_cnt_r - 8'h01;

    assign rx_buffer_count = rx_cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // automatic pause from the watermarks, full takes precedence
    logic [7:0] full_mark;
    logic [7:0] empty_mark;

    assign full_mark = wm_r[flow_stats_pkg::wm_full_lsb +: 8];
    assign empty_mark = wm_r[flow_stats_pkg::wm_empty_lsb +: 8];

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            auto_active_r <= 1'b0;
        else if (!ctrl_r[flow_stats_pkg::ctrl_auto_pause_bit])
            auto_active_r <= 1'b0;
        else if (rx_cnt_r >= full_mark)
            auto_active_r <= 1'b1;
        else if (rx_cnt_r <= empty_mark)
            auto_active_r <= 1'b0;

    assign flow_control_on = auto_active_r;

    ////////////////////////////////////////////////////////////////////////////
    // single collision frame counter
    logic col_evt;
    logic rd_clear;
    logic [15:0] col_base;

    assign col_evt = col_s2_r ^ col_s3_r;
    assign rd_clear = rd_ok && hit_col && (alias_kind == flow_stats_pkg::alias_write)
        && (reg_byte_en[0] || reg_byte_en[1]);

    always_comb
    begin
        col_base = col_cnt_r;
        if (wr_ok && hit_col)
        begin
            col_base = col_alias_nxt[15:0];
        end
        else if (rd_clear)
        begin
            col_base = 16'h0000;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            col_s1_r <= 1'b0;
            col_s2_r <= 1'b0;
            col_s3_r <= 1'b0;
        end
        else
        begin
            col_s1_r <= col_tgl_r;
            col_s2_r <= col_s1_r;
            col_s3_r <= col_s2_r;
        end
    end

    // a frame counted in the clearing cycle survives the clear
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            col_cnt_r <= flow_stats_pkg::collision_reset;
        else if (col_evt)
            col_cnt_r <= col_base + 16'h0001;
        else
            col_cnt_r <= col_base;

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; aliases and holes read zero
    logic [31:0] rd_word;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (alias_kind != flow_stats_pkg::alias_write)
            rd_word = 32'h0000_0000;
        else if (hit_ctrl)
            rd_word = ctrl_r;
        else if (hit_ptv)
            rd_word = {16'h0000, ptv_r};
        else if (hit_wm)
            rd_word = {16'h0000, wm_r};
        else if (hit_status)
        begin
            rd_word[flow_stats_pkg::status_count_lsb +: 8] = rx_cnt_r;
            rd_word[flow_stats_pkg::status_pause_bit] = auto_active_r;
        end
        else if (hit_col)
            rd_word = {16'h0000, col_cnt_r};
        else if (hit_phy)
            rd_word = phy_r;
    end

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            rdata_r <= 32'h0000_0000;
        else if (rd_ok)
            rdata_r <= rd_word & lane_mask;
        else
            rdata_r <= 32'h0000_0000;

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // tx clock domain: synchronisers
    always_ff @(posedge tx_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            man_s1_r <= 1'b0;
            man_s2_r <= 1'b0;
            hold_s1_r <= 1'b0;
            hold_s2_r <= 1'b0;
            ptv_s1_r <= 1'b0;
            ptv_s2_r <= 1'b0;
            ptv_s3_r <= 1'b0;
        end
        else
        begin
            man_s1_r <= ctrl_r[flow_stats_pkg::ctrl_manual_pause_bit];
            man_s2_r <= man_s1_r;
            hold_s1_r <= phy_r[flow_stats_pkg::phy_reset_bit];
            hold_s2_r <= hold_s1_r;
            ptv_s1_r <= ptv_tgl_r;
            ptv_s2_r <= ptv_s1_r;
            ptv_s3_r <= ptv_s2_r;
        end
    end

    // pause value taken once its toggle has settled across the crossing
    always_ff @(posedge tx_clock or negedge resetn)
        if (!resetn)
            tx_ptv_r <= flow_stats_pkg::pause_timer_reset;
        else if (ptv_s2_r ^ ptv_s3_r)
            tx_ptv_r <= ptv_r;

    always_ff @(posedge tx_clock or negedge resetn)
        if (!resetn)
            col_tgl_r <= 1'b0;
        else if (second_try_tx_done && !hold_s2_r)
            col_tgl_r <= ~col_tgl_r;

    ////////////////////////////////////////////////////////////////////////////
    // manual pause frame scheduling
    logic [21:0] resend_interval;

    assign resend_interval = 22'(tx_ptv_r) * 22'(flow_stats_pkg::resend_scale);

    always_ff @(posedge tx_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pause_state_r <= flow_stats_pkg::pause_idle;
            resend_cnt_r <= 22'h000000;
            pause_send_r <= 1'b0;
            pause_value_r <= flow_stats_pkg::pause_zero_value;
        end
        else if (hold_s2_r)
        begin
            pause_state_r <= flow_stats_pkg::pause_idle;
            resend_cnt_r <= 22'h000000;
            pause_send_r <= 1'b0;
            pause_value_r <= flow_stats_pkg::pause_zero_value;
        end
        else
        begin
            pause_send_r <= 1'b0;
            case (pause_state_r)
                flow_stats_pkg::pause_idle:
                begin
                    if (man_s2_r)
                    begin
                        pause_send_r <= 1'b1;
                        pause_value_r <= tx_ptv_r;
                        resend_cnt_r <= resend_interval - 22'h000001;
                        pause_state_r <= flow_stats_pkg::pause_running;
                    end
                end
                flow_stats_pkg::pause_running:
                begin
                    if (!man_s2_r)
                    begin
                        pause_send_r <= 1'b1;
                        pause_value_r <= flow_stats_pkg::pause_zero_value;
                        pause_state_r <= flow_stats_pkg::pause_idle;
                    end
                    else if (resend_cnt_r == 22'h000000)
                    begin
                        pause_send_r <= (tx_ptv_r != 16'h0000);
                        pause_value_r <= tx_ptv_r;
                        resend_cnt_r <= resend_interval - 22'h000001;
                    end
                    else
                    begin
                        resend_cnt_r <= resend_cnt_r - 22'h000001;
                    end
                end
                default:
                begin
                    pause_state_r <= flow_stats_pkg::pause_idle;
                end
            endcase
        end
    end

    assign pause_frame_send = pause_send_r;
    assign pause_frame_value = pause_value_r;

endmodule

/* sim/flow_stats_sva.sv */
`timescale 1ns/100ps
module flow_stats_sva
(
    // clocks and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic tx_clock,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0] reg_byte_en,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // receive and control outputs
    input wire logic rx_buffer_increment,
    input wire logic [7:0] rx_buffer_count,
    input wire logic flow_control_on,
    input wire logic controller_on,
    input wire logic receive_path_enable,
    input wire logic reduced_phy_if_reset,
    input wire logic reduced_phy_if_speed,
    // link side
    input wire logic second_try_tx_done,
    input wire logic pause_frame_send,
    input wire logic [15:0] pause_frame_value
);
    sequence s_wr(a);
        reg_write && reg_addr == a && reg_byte_en == 4'hf;
    endsequence
    sequence s_dec;
        s_wr(12'h000) ##0 reg_wdata[0];
    endsequence

    a_dec_lower: assert property (@(posedge clock) disable iff (!resetn)
        s_dec ##0 (!rx_buffer_increment && rx_buffer_count != 8'h0)
        |=> rx_buffer_count == $past(rx_buffer_count) - 8'h1) else $error("no decrement");
    a_dec_inc_hold: assert property (@(posedge clock) disable iff (!resetn)
        s_dec ##0 rx_buffer_increment |=> $stable(rx_buffer_count))
        else $error("count moved on clash");
    a_dec_reads_zero: assert property (@(posedge clock) disable iff (!resetn)
        reg_read && reg_addr == 12'h000 |=> !reg_rdata[0]) else $error("decrement bit read 1");
    a_byte_ignored: assert property (@(posedge clock) disable iff (!resetn)
        reg_write && reg_byte_en == 4'h1 |=> $stable({controller_on, receive_path_enable,
        reduced_phy_if_reset, reduced_phy_if_speed})) else $error("byte write taken");
    a_phy_upper_zero: assert property (@(posedge clock) disable iff (!resetn)
        reg_read && reg_addr == 12'h050 |=> reg_rdata[31:12] == 20'h0)
        else $error("phy upper bits set");
    a_phy_write: assert property (@(posedge clock) disable iff (!resetn)
        s_wr(12'h050) |=> {reduced_phy_if_reset, reduced_phy_if_speed}
        == {$past(reg_wdata[11]), $past(reg_wdata[8])}) else $error("phy bits wrong");
    a_phy_clear_alias: assert property (@(posedge clock) disable iff (!resetn)
        s_wr(12'h054) |=> reduced_phy_if_speed
        == ($past(reduced_phy_if_speed) & ~$past(reg_wdata[8]))) else $error("clear alias");
    a_pause_single: assert property (@(posedge tx_clock) disable iff (!resetn)
        pause_frame_send |=> !pause_frame_send [*2]) else $error("pause pulse too long");
    a_link_reset_idle: assert property (@(posedge tx_clock) disable iff (!resetn)
        reduced_phy_if_reset [*4] |-> !pause_frame_send && pause_frame_value == 16'h0)
        else $error("pause active in link reset");
endmodule

bind ethernet_flow_control_stats flow_stats_sva flow_stats_sva_i (.clock(clock),
    .resetn(resetn), .tx_clock(tx_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_byte_en(reg_byte_en), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rx_buffer_increment(rx_buffer_increment),
    .rx_buffer_count(rx_buffer_count), .flow_control_on(flow_control_on),
    .controller_on(controller_on), .receive_path_enable(receive_path_enable),
    .reduced_phy_if_reset(reduced_phy_if_reset), .reduced_phy_if_speed(reduced_phy_if_speed),
    .second_try_tx_done(second_try_tx_done), .pause_frame_send(pause_frame_send),
    .pause_frame_value(pause_frame_value));

/* sim/phy_link_model.sv */
`timescale 1ns/100ps
module phy_link_model
(
    // link clock
    input wire logic tx_clock,
    // pause requests from the mac
    input wire logic pause_frame_send,
    input wire logic [15:0] pause_frame_value,
    // transmit outcome
    output logic second_try_tx_done
);
    int sends = 0;
    int gap = 0;
    int since = 0;
    logic [15:0] last_value = 16'h0;
    initial second_try_tx_done = 1'b0;

    // spacing of pause frames measured in tx clock edges
    always @(posedge tx_clock)
    begin
        since <= since + 1;
        if (pause_frame_send === 1'b1)
        begin
            sends <= sends + 1;
            gap <= since + 1;
            since <= 0;
            last_value <= pause_frame_value;
        end
    end

    // frames sent after one collision, spaced for the crossing
    task send_events(input int n);
        repeat (n)
        begin
            @(posedge tx_clock);
            second_try_tx_done <= 1'b1;
            @(posedge tx_clock);
            second_try_tx_done <= 1'b0;
            repeat (4) @(posedge tx_clock);
        end
    endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic clock, resetn, tx_clock, reg_write, reg_read, rx_buffer_increment;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_data;
    logic [3:0] reg_byte_en;
    logic [7:0] rx_buffer_count;
    logic flow_control_on, controller_on, receive_path_enable;
    logic reduced_phy_if_reset, reduced_phy_if_speed, second_try_tx_done;
    logic pause_frame_send;
    logic [15:0] pause_frame_value;
    int err_total = 0;
    int samples_checked = 0;

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial
    begin
        tx_clock = 1'b0;
        #1.3;
        forever #3 tx_clock = ~tx_clock;
    end

    ethernet_flow_control_stats ethernet_flow_control_stats_i (.clock(clock), .resetn(resetn),
        .tx_clock(tx_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_byte_en(reg_byte_en), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .rx_buffer_increment(rx_buffer_increment),
        .rx_buffer_count(rx_buffer_count), .flow_control_on(flow_control_on),
        .controller_on(controller_on), .receive_path_enable(receive_path_enable),
        .reduced_phy_if_reset(reduced_phy_if_reset), .reduced_phy_if_speed(reduced_phy_if_speed),
        .second_try_tx_done(second_try_tx_done), .pause_frame_send(pause_frame_send),
        .pause_frame_value(pause_frame_value));
    phy_link_model phy_i (.tx_clock(tx_clock), .pause_frame_send(pause_frame_send),
        .pause_frame_value(pause_frame_value), .second_try_tx_done(second_try_tx_done));

    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // one strobe cycle; read data sampled in the cycle after the strobe
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clock);
        reg_write <= w;
        reg_read <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        reg_byte_en <= b;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        #1 rd_data = reg_rdata;
    endtask

    task inc(input int n);
        repeat (n)
        begin
            @(posedge clock);
            rx_buffer_increment <= 1'b1;
            @(posedge clock);
            rx_buffer_increment <= 1'b0;
        end
    endtask

    task wait_sends(input int n);
        int k;
        k = 0;
        while (phy_i.sends < n && k < 3000)
        begin
            @(posedge clock);
            k++;
        end
        if (k == 3000)
        begin
            err_total++;
            $display("[FAIL] %0t no pause frame", $time);
            end_sim;
        end
    endtask

    task t_phy;
        bus(1, 12'h050, 32'hffff_ffff, 4'hf);
        bus(0, 12'h050, 0, 4'hf);
        chk(rd_data, 32'h0000_0900, "phy readback");
        chk(32'({reduced_phy_if_reset, reduced_phy_if_speed}), 32'h3, "phy pins");
        bus(1, 12'h054, 32'h0000_0800, 4'hf);
        bus(0, 12'h050, 0, 4'hf);
        chk(rd_data, 32'h0000_0100, "clear alias");
        bus(1, 12'h05c, 32'h0000_0900, 4'hf);
        bus(0, 12'h050, 0, 4'hf);
        chk(rd_data, 32'h0000_0800, "invert alias");
        bus(1, 12'h058, 32'h0000_0100, 4'h3);
        bus(1, 12'h054, 32'h0000_0900, 4'h1);
        bus(0, 12'h050, 0, 4'hf);
        chk(rd_data, 32'h0000_0900, "half set, byte ignored");
        bus(0, 12'h050, 0, 4'h1);
        chk(rd_data, 32'h0, "byte read");
        bus(1, 12'h050, 0, 4'hf);
        chk(32'({reduced_phy_if_reset, reduced_phy_if_speed}), 32'h0, "phy pins off");
        bus(0, 12'h0f0, 0, 4'hf);
        chk(rd_data, 32'h0, "unmapped");
    endtask

    task t_decrement;
        inc(5);
        bus(1, 12'h000, 32'h1, 4'hf);
        bus(1, 12'h000, 32'h0, 4'hf);
        bus(0, 12'h030, 0, 4'hf);
        chk(rd_data, 32'h0004_0000, "count after dec");
        fork
            inc(1);
            bus(1, 12'h000, 32'h1, 4'hf);
        join
        bus(0, 12'h030, 0, 4'hf);
        chk(rd_data, 32'h0004_0000, "count on clash");
    endtask

    task t_auto;
        bus(1, 12'h020, 32'h0000_0206, 4'hf);
        bus(1, 12'h008, 32'h0000_8180, 4'hf);
        chk(32'({controller_on, receive_path_enable}), 32'h3, "ctrl pins");
        inc(1);
        repeat (3) @(posedge clock);
        chk(32'(flow_control_on), 32'h0, "below full");
        inc(1);
        repeat (3) @(posedge clock);
        chk(32'(flow_control_on), 32'h1, "at full");
        repeat (3) bus(1, 12'h008, 32'h1, 4'hf);
        repeat (2) @(posedge clock);
        chk(32'(flow_control_on), 32'h1, "above empty");
        bus(1, 12'h008, 32'h1, 4'hf);
        repeat (2) @(posedge clock);
        chk(32'(flow_control_on), 32'h0, "at empty");
        bus(0, 12'h000, 0, 4'hf);
        chk(rd_data, 32'h0000_8180, "ctrl readback");
        bus(1, 12'h004, 32'h0000_0080, 4'hf);
    endtask

    task t_link_reset;
        bus(1, 12'h058, 32'h0000_0800, 4'hf);
        repeat (4) @(posedge clock);
        phy_i.send_events(2);
        repeat (10) @(posedge clock);
        bus(0, 12'h040, 0, 4'hf);
        chk(rd_data, 32'h0, "events in link reset");
        bus(1, 12'h054, 32'h0000_0800, 4'hf);
        repeat (4) @(posedge clock);
    endtask

    task t_collision;
        phy_i.send_events(3);
        repeat (10) @(posedge clock);
        bus(0, 12'h040, 0, 4'hc);
        chk(rd_data, 32'h0, "upper lanes only");
        bus(0, 12'h040, 0, 4'hf);
        chk(rd_data, 32'h3, "second try count");
        bus(0, 12'h040, 0, 4'hf);
        chk(rd_data, 32'h0, "cleared by read");
    endtask

    task t_manual;
        bus(1, 12'h010, 32'h2, 4'hf);
        repeat (8) @(posedge clock);
        bus(1, 12'h008, 32'h10, 4'hf);
        wait_sends(1);
        chk(32'(phy_i.last_value), 32'h2, "first pause value");
        wait_sends(2);
        chk(phy_i.gap, 32'd128, "resend spacing");
        bus(1, 12'h004, 32'h10, 4'hf);
        wait_sends(3);
        chk(32'(phy_i.last_value), 32'h0, "zero pause value");
        repeat (300) @(posedge clock);
        chk(phy_i.sends, 32'd3, "no more frames");
    endtask

    initial
    begin
        resetn = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 12'h0;
        reg_wdata = 32'h0;
        reg_byte_en = 4'h0;
        rx_buffer_increment = 1'b0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        t_phy;
        t_decrement;
        t_auto;
        t_link_reset;
        t_collision;
        t_manual;
        end_sim;
    end
endmodule
